/* File: design/lfc_drive.sv */
// Purpose: registered decode of the actual line state into drive controls
// Assumes: state comes from logic on clk
// Notes: outputs follow the state one clock later
`timescale 1ns/1ps
`default_nettype none
module lfc_drive
    import lfc_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       reset_n,
    input  wire lfc_state_t state,
    input  wire logic       batt_mode,
    output var  logic       tip_drive_en,
    output var  logic       ring_drive_en,
    output var  logic       tip_positive,
    output var  logic       ring_positive,
    output var  logic       audio_power_en,
    output var  logic       ringing_en,
    output var  logic       calib_en,
    output var  logic       dcdc_en,
    output var  logic       batt_switch_en,
    output var  logic       batt_high_sel
);
    logic [9:0] next_ctl;
    logic [6:0] lead;

    // per-state lead map: tip, ring, tip+, ring+, audio, ringing, calib
    always_comb begin
        case (state)
            LFC_OPEN:     lead = 7'b0000000;
            LFC_FWD_ACT:  lead = 7'b1110100;
            LFC_FWD_OHT:  lead = 7'b1110100;
            LFC_TIP_OPEN: lead = 7'b0100000;
            LFC_RINGING:  lead = 7'b1100010;
            LFC_REV_ACT:  lead = 7'b1101100;
            LFC_REV_OHT:  lead = 7'b1101100;
            LFC_RING_OPN: lead = 7'b1000000;
            LFC_FWD_IDLE: lead = 7'b1110000;
            LFC_REV_IDLE: lead = 7'b1101000;
            LFC_CALIB:    lead = 7'b1100001;
            default:      lead = 7'b0000000;
        endcase
        // supply mode from the battery pin; high battery select also needs the ringing state
        next_ctl = {lead, !batt_mode, batt_mode,
                    batt_mode && (state == LFC_RINGING)};
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            {tip_drive_en, ring_drive_en, tip_positive, ring_positive,
             audio_power_en, ringing_en, calib_en, dcdc_en,
             batt_switch_en, batt_high_sel} <= 10'h000;
        end else begin
            {tip_drive_en, ring_drive_en, tip_positive, ring_positive,
             audio_power_en, ringing_en, calib_en, dcdc_en,
             batt_switch_en, batt_high_sel} <= next_ctl;
        end
    end
endmodule // lfc_drive
`default_nettype wire

/* File: design/lfc_pkg.sv */
// Purpose: shared constants and types for the linefeed state control block
// Assumes: 8-bit register port, 20 MHz clk, synchronous active-low reset
// Notes: register offsets are byte addresses on the plain register port
package lfc_pkg;

    // register offsets
    localparam logic [7:0] LFC_ADDR_AUTO   = 8'h43;
    localparam logic [7:0] LFC_ADDR_STATE  = 8'h44;
    localparam logic [7:0] LFC_ADDR_OHV    = 8'h4C;
    localparam logic [7:0] LFC_ADDR_ALARM  = 8'h50;
    localparam logic [7:0] LFC_ADDR_THRESH = 8'h51;

    // field positions
    localparam int LFC_BIT_LOOP_AUTO  = 0;
    localparam int LFC_BIT_RING_AUTO  = 1;
    localparam int LFC_BIT_ALARM_AUTO = 2;
    localparam int LFC_BIT_SIGN       = 6;

    // values after reset
    localparam logic [7:0] LFC_RST_AUTO   = 8'h00;
    localparam logic [7:0] LFC_RST_OHV    = 8'h20;
    localparam logic [7:0] LFC_RST_THRESH = 8'h80;

    // linefeed states, codes fixed by the line state field
    typedef enum logic [3:0] {
        LFC_OPEN     = 4'h0,
        LFC_FWD_ACT  = 4'h1,
        LFC_FWD_OHT  = 4'h2,
        LFC_TIP_OPEN = 4'h3,
        LFC_RINGING  = 4'h4,
        LFC_REV_ACT  = 4'h5,
        LFC_REV_OHT  = 4'h6,
        LFC_RING_OPN = 4'h7,
        LFC_FWD_IDLE = 4'h9,
        LFC_REV_IDLE = 4'hD,
        LFC_CALIB    = 4'hE
    } lfc_state_t;

    // true for the eleven defined codes
    function automatic logic lfc_valid(input logic [3:0] code);
        lfc_valid = (code != 4'h8) && (code != 4'hA) && (code != 4'hB)
                    && (code != 4'hC) && (code != 4'hF);
    endfunction

endpackage

/* File: design/lfc_sync.sv */
// Purpose: two-flop synchroniser for pin inputs
// Assumes: inputs are asynchronous levels
// Notes: the first stage feeds only the second stage
`timescale 1ns/1ps
`default_nettype none
module lfc_sync #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         reset_n,
    input  wire logic [W-1:0] async_in,
    output var  logic [W-1:0] sync_out
);
    logic [W-1:0] stage1;

    // plain double flop, reset clears both stages
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            stage1   <= '0;
            sync_out <= '0;
        end else begin
            stage1   <= async_in;
            sync_out <= stage1;
        end
    end
endmodule // lfc_sync
`default_nettype wire

/* File: design/lfc_top.sv */
// Purpose: linefeed state register, automatic transitions, power alarms
// Assumes: power readings and ring burst come from logic on clk
// Notes: detector pins and the battery pin are synchronised here
//
// Local design decision: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module lfc_top
    import lfc_pkg::*;
#(
    parameter int NPOS = 3
) (
    input  wire logic            clk,
    input  wire logic            reset_n,
    input  wire logic [7:0]      addr,
    input  wire logic [7:0]      wr_data,
    input  wire logic            wr_en,
    input  wire logic            rd_en,
    output var  logic [7:0]      rd_data,
    input  wire logic            ring_trip_pin,
    input  wire logic            loop_closed_pin,
    input  wire logic            battery_mode_pin,
    input  wire logic            ring_burst,
    input  wire logic [NPOS*8-1:0] tip_power,
    input  wire logic [NPOS*8-1:0] ring_power,
    output var  logic            tip_drive_en,
    output var  logic            ring_drive_en,
    output var  logic            tip_positive,
    output var  logic            ring_positive,
    output var  logic            audio_power_en,
    output var  logic            ringing_en,
    output var  logic            calib_en,
    output var  logic            dcdc_en,
    output var  logic            batt_switch_en,
    output var  logic            batt_high_sel
);
    logic [2:0]      pins_s;
    logic            trip_s;
    logic            loop_s;
    logic            mode_s;
    lfc_state_t      line_state_field;
    lfc_state_t      next_line_state_field;
    lfc_state_t      actual_state_shadow;
    logic [7:0]      auto_transition_control;
    logic [7:0]      next_auto;
    logic [7:0]      onhook_voltage_setting;
    logic [7:0]      next_ohv;
    logic [7:0]      thresh [NPOS];
    logic [7:0]      next_thresh [NPOS];
    logic [2*NPOS-1:0] alarm_flags;
    logic [2*NPOS-1:0] next_alarm_flags;
    logic [2*NPOS-1:0] over;
    logic [2*NPOS-1:0] over_q;
    logic            alarm_rise;
    logic [7:0]      next_rd_data;
    logic            rev;
    lfc_state_t      auto_act;
    lfc_state_t      auto_idle;
    logic            st_wr;

    // pins cross into clk through two flops before any use
    lfc_sync #(
        .W        (3)
    ) u_sync (
        .clk      (clk),
        .reset_n  (reset_n),
        .async_in ({ring_trip_pin, loop_closed_pin, battery_mode_pin}),
        .sync_out (pins_s)
    );
    assign {trip_s, loop_s, mode_s} = pins_s;

    // both leads of one position compare against one shared threshold
    for (genvar i = 0; i < NPOS; i++) begin : g_cmp
        assign over[i]      = tip_power[i*8 +: 8] > thresh[i];
        assign over[NPOS+i] = ring_power[i*8 +: 8] > thresh[i];
    end

    // a new alarm is any transistor crossing into overload
    assign alarm_rise = |(over & ~over_q);

    // polarity for automatic moves comes from the sign bit only
    assign rev       = onhook_voltage_setting[LFC_BIT_SIGN];
    assign auto_act  = rev ? LFC_REV_ACT : LFC_FWD_ACT;
    assign auto_idle = rev ? LFC_REV_IDLE : LFC_FWD_IDLE;
    assign st_wr     = wr_en && (addr == LFC_ADDR_STATE);

    // shadow shows ringing or on-hook transmission across cadence
    always_comb begin
        actual_state_shadow = line_state_field;
        if (line_state_field == LFC_RINGING && !ring_burst) begin
            actual_state_shadow = rev ? LFC_REV_OHT : LFC_FWD_OHT;
        end
    end

    // programmed state: power alarm beats software, software beats autos
    always_comb begin
        next_line_state_field = line_state_field;
        if (st_wr) begin
            if (lfc_valid(wr_data[3:0])) begin
                // written code is taken as is, variant included
                next_line_state_field = lfc_state_t'(wr_data[3:0]);
            end
            // undefined codes leave the field alone
        end else if (auto_transition_control[LFC_BIT_RING_AUTO]
                     && line_state_field == LFC_RINGING && trip_s) begin
            next_line_state_field = auto_act;
        end else if (auto_transition_control[LFC_BIT_LOOP_AUTO]) begin
            case (line_state_field)
                LFC_FWD_OHT, LFC_REV_OHT, LFC_FWD_IDLE, LFC_REV_IDLE,
                LFC_TIP_OPEN, LFC_RING_OPN: begin
                    if (loop_s) begin
                        next_line_state_field = auto_act;
                    end
                end
                LFC_FWD_ACT, LFC_REV_ACT: begin
                    if (!loop_s) begin
                        next_line_state_field = auto_idle;
                    end
                end
                default: begin
                    next_line_state_field = line_state_field;
                end
            endcase
        end
        // protecting the transistors outranks everything else
        if (auto_transition_control[LFC_BIT_ALARM_AUTO] && alarm_rise) begin
            next_line_state_field = LFC_OPEN;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            line_state_field <= LFC_OPEN;
        end else begin
            line_state_field <= next_line_state_field;
        end
    end

    // software-written registers; shadow bits are read only
    always_comb begin
        next_auto = auto_transition_control;
        next_ohv  = onhook_voltage_setting;
        for (int i = 0; i < NPOS; i++) begin
            next_thresh[i] = thresh[i];
            if (wr_en && addr == LFC_ADDR_THRESH + 8'(i)) begin
                next_thresh[i] = wr_data;
            end
        end
        if (wr_en && addr == LFC_ADDR_AUTO) begin
            next_auto = wr_data;
        end
        if (wr_en && addr == LFC_ADDR_OHV) begin
            next_ohv = wr_data;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            auto_transition_control <= LFC_RST_AUTO;
            onhook_voltage_setting  <= LFC_RST_OHV;
            for (int i = 0; i < NPOS; i++) begin
                thresh[i] <= LFC_RST_THRESH;
            end
        end else begin
            auto_transition_control <= next_auto;
            onhook_voltage_setting  <= next_ohv;
            for (int i = 0; i < NPOS; i++) begin
                thresh[i] <= next_thresh[i];
            end
        end
    end

    // one sticky bit per transistor, write one to clear, set wins
    always_comb begin
        next_alarm_flags = alarm_flags;
        if (wr_en && addr == LFC_ADDR_ALARM) begin
            next_alarm_flags = alarm_flags & ~wr_data[2*NPOS-1:0];
        end
        next_alarm_flags = next_alarm_flags | over;
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            alarm_flags <= '0;
            over_q      <= '0;
        end else begin
            alarm_flags <= next_alarm_flags;
            over_q      <= over;
        end
    end

    // read data stand in the cycle after the strobe, unmapped reads zero
    always_comb begin
        next_rd_data = 8'h00;
        if (rd_en) begin
            case (addr)
                LFC_ADDR_AUTO:  next_rd_data = auto_transition_control;
                LFC_ADDR_STATE: next_rd_data = {actual_state_shadow,
                                                line_state_field};
                LFC_ADDR_OHV:   next_rd_data = onhook_voltage_setting;
                LFC_ADDR_ALARM: next_rd_data = 8'(alarm_flags);
                default: begin
                    for (int i = 0; i < NPOS; i++) begin
                        if (addr == LFC_ADDR_THRESH + 8'(i)) begin
                            next_rd_data = thresh[i];
                        end
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            rd_data <= 8'h00;
        end else begin
            rd_data <= next_rd_data;
        end
    end

    // lead controls decoded from the actual state, supply controls from the battery pin (high select also from state)
    lfc_drive u_drive (
        .clk            (clk),
        .reset_n        (reset_n),
        .state          (actual_state_shadow),
        .batt_mode      (mode_s),
        .tip_drive_en   (tip_drive_en),
        .ring_drive_en  (ring_drive_en),
        .tip_positive   (tip_positive),
        .ring_positive  (ring_positive),
        .audio_power_en (audio_power_en),
        .ringing_en     (ringing_en),
        .calib_en       (calib_en),
        .dcdc_en        (dcdc_en),
        .batt_switch_en (batt_switch_en),
        .batt_high_sel  (batt_high_sel)
    );

    // checks on the state register and the decoded drive
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);

    a_bad_code_kept:
    assert property (st_wr && !lfc_valid(wr_data[3:0]) && !alarm_rise
                     |=> $stable(line_state_field))
    else $error("undefined state code changed the state");

    a_write_applies:
    assert property (st_wr && lfc_valid(wr_data[3:0]) && !alarm_rise
                     |=> line_state_field == $past(wr_data[3:0]))
    else $error("valid state write not applied");

    a_open_on_alarm:
    assert property (auto_transition_control[LFC_BIT_ALARM_AUTO]
                     && alarm_rise |=> line_state_field == LFC_OPEN
                     ##1 !tip_drive_en && !ring_drive_en)
    else $error("power alarm did not open the line");

    a_ring_trip_act:
    assert property (!st_wr && !alarm_rise && trip_s
                     && auto_transition_control[LFC_BIT_RING_AUTO]
                     && line_state_field == LFC_RINGING
                     |=> line_state_field == ($past(rev) ? LFC_REV_ACT
                                                         : LFC_FWD_ACT))
    else $error("ring trip did not reach active");

    a_loop_drop_idle:
    assert property (!st_wr && !alarm_rise && !loop_s
                     && auto_transition_control[LFC_BIT_LOOP_AUTO]
                     && line_state_field inside {LFC_FWD_ACT, LFC_REV_ACT}
                     |=> line_state_field inside {LFC_FWD_IDLE,
                                                  LFC_REV_IDLE})
    else $error("loop release did not drop to idle");

    a_polarity_leads:
    assert property (actual_state_shadow inside {LFC_FWD_ACT, LFC_FWD_OHT,
                     LFC_FWD_IDLE} |=> tip_positive && !ring_positive)
    else $error("forward state without tip positive");

    a_idle_audio_off:
    assert property (actual_state_shadow inside {LFC_FWD_IDLE,
                     LFC_REV_IDLE} |=> tip_drive_en && ring_drive_en
                     && !audio_power_en)
    else $error("idle state drive or audio wrong");

    a_calib_equal:
    assert property (actual_state_shadow == LFC_CALIB |=> calib_en
                     && !tip_positive && !ring_positive)
    else $error("calibration leads not held equal");

    a_cadence_shadow:
    assert property (line_state_field == LFC_RINGING && !ring_burst
                     && rd_en && addr == LFC_ADDR_STATE
                     |=> rd_data[3:0] == LFC_RINGING
                     && rd_data[7:4] != LFC_RINGING)
    else $error("shadow does not follow cadence");

    a_alarm_sticky:
    // checked on the very next edge, before a write-one clear can land
    assert property (over != '0 |=> (alarm_flags & $past(over))
                     == $past(over))
    else $error("overload did not set its alarm bit");

    a_batt_mode:
    assert property (mode_s |=> !dcdc_en && batt_switch_en)
    else $error("battery pin mode not applied");

    c_ring_trip: cover property (line_state_field == LFC_RINGING
                                 ##1 line_state_field == auto_act);
    c_alarm_open: cover property (alarm_rise
                                  && auto_transition_control[LFC_BIT_ALARM_AUTO]);
    c_loop_cycle: cover property (line_state_field == LFC_FWD_IDLE
                                  ##[1:20] line_state_field == LFC_FWD_ACT);
    c_calib: cover property (line_state_field == LFC_CALIB);

endmodule // lfc_top
`default_nettype wire

/* File: verification/lfc_line.sv */
// Purpose: line side model, subscriber loop and transistor load
// Assumes: drive levels come from lfc_top on the same clock
// Notes: power readings follow the drive with no delay
`timescale 1ns/1ps
`default_nettype none
module lfc_line #(
    parameter int NPOS = 3
) (
    input  wire logic              off_hook,
    input  wire logic [7:0]        heat,
    input  wire logic              tip_drive_en,
    input  wire logic              ring_drive_en,
    input  wire logic              ringing_en,
    output var  logic              ring_trip_pin,
    output var  logic              loop_closed_pin,
    output var  logic [NPOS*8-1:0] tip_power,
    output var  logic [NPOS*8-1:0] ring_power
);
    // discrete feed, a tip and a ring transistor per position
    logic fed;

    // an off-hook loop draws dc only while some lead is fed
    always_comb begin
        fed             = tip_drive_en | ring_drive_en;
        loop_closed_pin = off_hook & fed & ~ringing_en;
        ring_trip_pin   = off_hook & ringing_en;
        tip_power       = fed ? {NPOS{8'h10}} : '0;
        ring_power      = tip_power;
        // unfed transistors cannot dissipate, so heat needs feed
        ring_power[15:8] = fed ? heat : 8'h00;
    end
endmodule // lfc_line
`default_nettype wire

/* File: verification/lfc_top_tb.sv */
// Purpose: self-checking bench for the linefeed state control block
// Assumes: autos off until a scenario enables them
// Notes: reads are checked by a monitor from a queue of expectations
`timescale 1ns/1ps
`default_nettype none
module lfc_top_tb;
    import lfc_pkg::*;
    localparam int NPOS = 3;
    logic                clk, reset_n, wr_en, rd_en, ring_burst;
    logic                off_hook, mode, pend, ring_trip_pin;
    logic                loop_closed_pin, tip_drive_en, ring_drive_en;
    logic                tip_positive, ring_positive, audio_power_en;
    logic                ringing_en, calib_en, dcdc_en, batt_switch_en;
    logic                batt_high_sel;
    logic [7:0]          addr, wr_data, rd_data, heat, ev;
    logic [7:0]          exp_q[$];
    logic [3:0]          rn;
    logic [NPOS*8-1:0]   tip_power, ring_power;
    int                  mismatches, n_checks, prev;

    lfc_top #(.NPOS(NPOS)) dut (.clk, .reset_n, .addr, .wr_data, .wr_en,
        .rd_en, .rd_data, .ring_trip_pin, .loop_closed_pin,
        .battery_mode_pin(mode), .ring_burst, .tip_power, .ring_power,
        .tip_drive_en, .ring_drive_en, .tip_positive, .ring_positive,
        .audio_power_en, .ringing_en, .calib_en, .dcdc_en,
        .batt_switch_en, .batt_high_sel);

    lfc_line #(.NPOS(NPOS)) line (.off_hook, .heat, .tip_drive_en,
        .ring_drive_en, .ringing_en, .ring_trip_pin, .loop_closed_pin,
        .tip_power, .ring_power);

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    task automatic fail(input string msg);
        mismatches++;
        $display("[ERR] %0t %s", $time, msg);
    endtask

    // each task drives every strobe once per cycle through cyc, so no double assignment
    task automatic cyc(input logic w, r, input logic [7:0] a, d);
        wr_en <= w;
        rd_en <= r;
        addr <= a;
        wr_data <= d;
        @(posedge clk);
    endtask

    task automatic wr(input logic [7:0] a, d);
        cyc(1'b1, 1'b0, a, d);
    endtask

    task automatic rd(input logic [7:0] a, e);
        exp_q.push_back(e);
        cyc(1'b0, 1'b1, a, 8'h00);
    endtask

    task automatic idle(input int n);
        repeat (n) cyc(1'b0, 1'b0, 8'h00, 8'h00);
    endtask

    // mask then value: tipdrv ringdrv tippos ringpos audio ring cal
    function automatic logic [13:0] dexp(input logic [3:0] c);
        case (c)
            4'h0: dexp = {7'h7F, 7'h00};
            4'h1, 4'h2: dexp = {7'h7F, 7'h74};
            4'h5, 4'h6: dexp = {7'h7F, 7'h6C};
            4'h9: dexp = {7'h7F, 7'h70};
            4'hD: dexp = {7'h7F, 7'h68};
            4'h3: dexp = {7'h63, 7'h20};
            4'h7: dexp = {7'h63, 7'h40};
            4'h4: dexp = {7'h03, 7'h02};
            default: dexp = {7'h03, 7'h01};
        endcase
    endfunction

    task automatic chk_out(input logic [3:0] c);
        logic [13:0] e;
        logic [6:0]  v;
        e = dexp(c);
        // sampled before this edge's updates, so values stand since earlier
        idle(3);
        v = {tip_drive_en, ring_drive_en, tip_positive, ring_positive,
             audio_power_en, ringing_en, calib_en};
        n_checks++;
        if (((v ^ e[6:0]) & e[13:7]) !== 7'h00)
            fail($sformatf("drive %b for state %h", v, c));
        n_checks++;
        if (batt_high_sel !== (mode && c == 4'h4))
            fail("battery switch select");
    endtask

    // read data stand only in the cycle after the strobe
    always @(posedge clk) begin
        if (pend) begin
            ev = exp_q.pop_front();
            n_checks++;
            if (rd_data !== ev)
                fail($sformatf("read %h want %h", rd_data, ev));
        end
        pend <= rd_en;
    end

    task automatic print_verdict;
        // a read whose answer never came counts against the run
        if (exp_q.size() != 0)
            fail("reads left unchecked");
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    initial begin
        repeat (5000) @(posedge clk);
        fail("watchdog");
        print_verdict();
    end

    initial begin
        {reset_n, wr_en, rd_en, off_hook, mode} = 5'h00;
        {addr, wr_data} = 16'h0000;
        ring_burst = 1'b1;
        heat = 8'h10;
        mismatches = 0;
        n_checks = 0;
        void'($urandom(79656));
        repeat (8) @(posedge clk);
        reset_n <= 1'b1;
        rd(LFC_ADDR_AUTO, LFC_RST_AUTO);
        rd(LFC_ADDR_STATE, 8'h00);
        rd(LFC_ADDR_OHV, LFC_RST_OHV);
        rd(8'h7E, 8'h00);
        for (int k = 0; k < 2; k++) begin
            mode <= k[0];
            idle(4);
            n_checks++;
            if ({dcdc_en, batt_switch_en} !== {~mode, mode})
                fail("battery mode");
        end
        // every code, random upper nibble; autos stay off meanwhile
        prev = 0;
        for (int c = 0; c < 16; c++) begin
            rn = 4'($urandom);
            wr(LFC_ADDR_STATE, {rn, c[3:0]});
            if (!(c inside {8, 10, 11, 12, 15}))
                prev = c;
            rd(LFC_ADDR_STATE, {prev[3:0], prev[3:0]});
            chk_out(prev[3:0]);
        end
        // software wrote forward, sign bit says reverse for autos
        wr(LFC_ADDR_OHV, 8'h40 | {4'h0, rn});
        rd(LFC_ADDR_OHV, 8'h40 | {4'h0, rn});
        wr(LFC_ADDR_AUTO, 8'h01);
        wr(LFC_ADDR_STATE, 8'h09);
        rd(LFC_ADDR_STATE, 8'h99);
        off_hook <= 1'b1;
        idle(8);
        rd(LFC_ADDR_STATE, 8'h55);
        chk_out(4'h5);
        off_hook <= 1'b0;
        idle(8);
        rd(LFC_ADDR_STATE, 8'hDD);
        // ringing with cadence gap, then trip to active
        wr(LFC_ADDR_OHV, 8'h20);
        wr(LFC_ADDR_AUTO, 8'h02);
        ring_burst <= 1'b0;
        wr(LFC_ADDR_STATE, 8'h04);
        idle(3);
        rd(LFC_ADDR_STATE, 8'h24);
        ring_burst <= 1'b1;
        idle(3);
        rd(LFC_ADDR_STATE, 8'h44);
        chk_out(4'h4);
        off_hook <= 1'b1;
        idle(8);
        rd(LFC_ADDR_STATE, 8'h11);
        off_hook <= 1'b0;
        // overload on ring transistor of position 1
        wr(LFC_ADDR_AUTO, 8'h04);
        wr(LFC_ADDR_STATE, 8'h01);
        heat <= 8'h80;
        idle(6);
        rd(LFC_ADDR_STATE, 8'h11);
        rd(LFC_ADDR_THRESH + 8'h01, LFC_RST_THRESH);
        heat <= 8'h81;
        idle(6);
        rd(LFC_ADDR_ALARM, 8'h10);
        rd(LFC_ADDR_STATE, 8'h00);
        chk_out(4'h0);
        heat <= 8'h10;
        wr(LFC_ADDR_ALARM, 8'h10);
        rd(LFC_ADDR_ALARM, 8'h00);
        idle(2);
        print_verdict();
    end
endmodule // lfc_top_tb
`default_nettype wire
